/* ligs_pkg.sv */
`default_nettype none

package ligs_pkg;

  // ------------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] OFF_MAP    = 8'h00;
  localparam logic [7:0] OFF_FORCE  = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_IRQ    = 8'h0C;
  localparam logic [7:0] OFF_MASK   = 8'h10;
  localparam logic [7:0] OFF_SPRCNT = 8'h14;

  // ------------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------------
  // map register: bit set means the logical input is mapped to a source
  localparam int MAP_ZONE   = 0;
  localparam int MAP_SPRING = 1;
  localparam int MAP_MSR    = 2;
  localparam int MAP_G2     = 3;
  localparam int MAP_G3     = 4;
  localparam int MAP_W      = 5;
  // force register: protocol command actuation of the input contacts
  localparam int FRC_ONE = 0;
  localparam int FRC_TWO = 1;
  // event bits
  localparam int EV_SPRING = 0;
  localparam int EV_GROUP  = 1;
  localparam int EV_W      = 2;

  localparam logic [MAP_W-1:0] MAP_RST = 5'h00;

  // unmapped defaults
  localparam logic ZONE_DEFAULT   = 1'b1;
  localparam logic SPRING_DEFAULT = 1'b0;
  localparam logic MSR_DEFAULT    = 1'b0;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_HZ       = 50_000_000;
  localparam int GROUP_DLY_PC = 2;   // power cycles

  typedef enum logic [1:0] {
    LIGS_PRIMARY,
    LIGS_ALT_ONE,
    LIGS_ALT_TWO
  } ligs_group_t;

  typedef struct packed {
    logic zone_coord_enable;
    logic multi_shot_reclose_enable;
    logic spring_event;
  } ligs_flags_t;

endpackage

`default_nettype wire

/* ligs_top.sv */
// Behaviour
// - zone coordination enable at 1 enables the zone sequence scheme.
// - unmapped zone coordination enable reads as logic 1.
// - spring charge contact at 1 logs a spring-charging event.
// - unmapped spring charge contact reads as logic 0.
// - spring charge contact acts only while breaker is open.
// - multi-shot enable at 1 permits multi-shot reclose after external open.
// - unmapped multi-shot reclose enable reads as logic 0.
// - three identical settings groups: primary, alternate one, alternate two.
// - two group-select inputs, mapped to contacts, choose alternate groups.
// - protocol commands may also actuate the programmable input contacts.
// - never more than one settings group active.
// - group two held while its select stays; then group one.
// - two power-cycle delay before new group applies, protection stays on; code waits for two pc_tick pulses, so one to two power cycles.
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module ligs_top #(
  parameter int PC_DIV = 833_333  // clocks per power cycle (60 Hz)
) (
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic        prog_input_one_in,
  input  wire logic        prog_input_two_in,
  input  wire logic        zone_coord_enable_in,
  input  wire logic        spring_charge_contact_in,
  input  wire logic        multi_shot_reclose_enable_in,
  input  wire logic        breaker_open_in,
  input  wire logic        external_open_in,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             zone_coord_active_out,
  output logic             multi_shot_permit_out,
  output logic             spring_event_out,
  output logic [2:0]       group_onehot_out,
  output logic             irq_out
);

  // dly_q is two bits wide, so the group delay must fit in it
  if (PC_DIV < 2 || ligs_pkg::GROUP_DLY_PC < 1 ||
      ligs_pkg::GROUP_DLY_PC > 4) begin : g_param_chk
    $error("ligs_top parameter out of range");
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  logic [ligs_pkg::MAP_W-1:0] map_q;
  logic [1:0]                 force_q;
  logic [ligs_pkg::EV_W-1:0]  irq_q;
  logic [ligs_pkg::EV_W-1:0]  mask_q;
  logic [15:0]                sprcnt_q;
  logic                       acc;
  logic                       wr;
  logic                       rd;
  logic [ligs_pkg::EV_W-1:0]  ev;

  assign acc = psel && penable;
  assign wr  = acc && pwrite;
  assign rd  = acc && !pwrite;

  function automatic logic bit_or_default(input logic mapped,
                                          input logic val,
                                          input logic dflt);
    return mapped ? val : dflt;
  endfunction

  // ------------------------------------------------------------------
  // logical inputs
  // ------------------------------------------------------------------
  logic zone_en;
  logic spring_lvl;
  logic msr;
  logic sel_two;
  logic sel_three;
  assign zone_en = bit_or_default(map_q[ligs_pkg::MAP_ZONE],
                                  zone_coord_enable_in,
                                  ligs_pkg::ZONE_DEFAULT);
  assign spring_lvl = bit_or_default(map_q[ligs_pkg::MAP_SPRING],
                                     spring_charge_contact_in,
                                     ligs_pkg::SPRING_DEFAULT);
  assign msr = bit_or_default(map_q[ligs_pkg::MAP_MSR],
                              multi_shot_reclose_enable_in,
                              ligs_pkg::MSR_DEFAULT);
  // contact closure or protocol command drives the input
  assign sel_two   = map_q[ligs_pkg::MAP_G2] &&
                     (prog_input_one_in || force_q[ligs_pkg::FRC_ONE]);
  assign sel_three = map_q[ligs_pkg::MAP_G3] &&
                     (prog_input_two_in || force_q[ligs_pkg::FRC_TWO]);

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      zone_coord_active_out <= 1'b0;
      multi_shot_permit_out <= 1'b0;
    end else begin
      zone_coord_active_out <= zone_en;
      multi_shot_permit_out <= msr && external_open_in;
    end
  end

  // ------------------------------------------------------------------
  // spring charge event: rising edge while breaker open
  // ------------------------------------------------------------------
  logic spring_seen_q;
  logic spring_ev;
  assign spring_ev = spring_lvl && !spring_seen_q && breaker_open_in;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      spring_seen_q    <= 1'b0;
      spring_event_out <= 1'b0;
      sprcnt_q         <= 16'h0000;
    end else begin
      spring_seen_q    <= spring_lvl && breaker_open_in;
      spring_event_out <= spring_ev;
      if (spring_ev) begin
        sprcnt_q <= sprcnt_q + 16'h0001;
      end
    end
  end

  // ------------------------------------------------------------------
  // power-cycle timebase
  // ------------------------------------------------------------------
  logic [31:0] div_q;
  logic        pc_tick;
  assign pc_tick = (div_q == 32'(PC_DIV - 1));

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      div_q <= 32'h0000_0000;
    end else begin
      div_q <= pc_tick ? 32'h0000_0000 : div_q + 32'h0000_0001;
    end
  end

  // ------------------------------------------------------------------
  // settings group selection
  // ------------------------------------------------------------------
  ligs_pkg::ligs_group_t req;
  ligs_pkg::ligs_group_t active_q;
  ligs_pkg::ligs_group_t pend_q;
  logic [1:0]            dly_q;
  logic                  grp_ev;

  always_comb begin
    // group two keeps priority while it is already active
    if (active_q == ligs_pkg::LIGS_ALT_TWO && sel_three) begin
      req = ligs_pkg::LIGS_ALT_TWO;
    end else if (sel_two) begin
      req = ligs_pkg::LIGS_ALT_ONE;
    end else if (sel_three) begin
      req = ligs_pkg::LIGS_ALT_TWO;
    end else begin
      req = ligs_pkg::LIGS_PRIMARY;
    end
  end

  // old group stays in force during the wait, so protection never lapses
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      active_q <= ligs_pkg::LIGS_PRIMARY;
      pend_q   <= ligs_pkg::LIGS_PRIMARY;
      dly_q    <= 2'h0;
      grp_ev   <= 1'b0;
    end else begin
      grp_ev <= 1'b0;
      if (req != pend_q) begin
        pend_q <= req;
        dly_q  <= 2'h0;
      end else if (pend_q != active_q && pc_tick) begin
        if (dly_q == 2'(ligs_pkg::GROUP_DLY_PC - 1)) begin
          active_q <= pend_q;
          grp_ev   <= 1'b1;
          dly_q    <= 2'h0;
        end else begin
          dly_q <= dly_q + 2'h1;
        end
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      group_onehot_out <= 3'h1;
    end else begin
      unique case (active_q)
        ligs_pkg::LIGS_PRIMARY: group_onehot_out <= 3'h1;
        ligs_pkg::LIGS_ALT_ONE: group_onehot_out <= 3'h2;
        ligs_pkg::LIGS_ALT_TWO: group_onehot_out <= 3'h4;
        default:                group_onehot_out <= 3'h1;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // interrupts
  // ------------------------------------------------------------------
  assign ev = {grp_ev, spring_ev};

  logic [ligs_pkg::EV_W-1:0] irq_d;

  // set wins over write-one-to-clear
  always_comb begin
    irq_d = irq_q | ev;
    if (wr && paddr == ligs_pkg::OFF_IRQ) begin
      irq_d = (irq_q & ~pwdata[ligs_pkg::EV_W-1:0]) | ev;
    end
  end

  // pin follows the next status, so a clear drops it with the bit
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      irq_q   <= '0;
      irq_out <= 1'b0;
    end else begin
      irq_q   <= irq_d;
      irq_out <= |(irq_d & mask_q);
    end
  end

  // ------------------------------------------------------------------
  // apb slave, zero wait states
  // ------------------------------------------------------------------
  logic bad;
  assign bad = !(paddr == ligs_pkg::OFF_MAP || paddr == ligs_pkg::OFF_FORCE ||
                 paddr == ligs_pkg::OFF_STATUS || paddr == ligs_pkg::OFF_IRQ ||
                 paddr == ligs_pkg::OFF_MASK || paddr == ligs_pkg::OFF_SPRCNT);

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      map_q   <= ligs_pkg::MAP_RST;
      force_q <= 2'h0;
      mask_q  <= '0;
    end else if (wr) begin
      unique case (paddr)
        ligs_pkg::OFF_MAP:   map_q   <= pwdata[ligs_pkg::MAP_W-1:0];
        ligs_pkg::OFF_FORCE: force_q <= pwdata[1:0];
        ligs_pkg::OFF_MASK:  mask_q  <= pwdata[ligs_pkg::EV_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && bad;
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          ligs_pkg::OFF_MAP:    prdata <= 32'(map_q);
          ligs_pkg::OFF_FORCE:  prdata <= 32'(force_q);
          ligs_pkg::OFF_STATUS: prdata <= {25'h0, group_onehot_out,
                                           sel_three, sel_two, msr, zone_en};
          ligs_pkg::OFF_IRQ:    prdata <= 32'(irq_q);
          ligs_pkg::OFF_MASK:   prdata <= 32'(mask_q);
          ligs_pkg::OFF_SPRCNT: prdata <= 32'(sprcnt_q);
          default:              prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  zone_follow_a: assert property (!$past(rst_in)
                  |-> zone_coord_active_out == $past(zone_en))
    else $error("zone enable mismatch");
  zone_dflt_a: assert property (!map_q[ligs_pkg::MAP_ZONE]
                  |=> zone_coord_active_out)
    else $error("zone default wrong");
  spring_log_a: assert property (spring_ev |=> spring_event_out)
    else $error("spring event lost");
  spring_dflt_a: assert property (!map_q[1] |=> !spring_event_out)
    else $error("spring default wrong");
  spring_closed_a: assert property (!breaker_open_in
                  |=> !spring_event_out)
    else $error("spring while closed");
  multi_dflt_a: assert property (!map_q[2] |=> !multi_shot_permit_out)
    else $error("multi default wrong");
  one_group_a: assert property ($onehot(group_onehot_out))
    else $error("group not one-hot");
  hold_two_a: assert property (active_q == ligs_pkg::LIGS_ALT_TWO
                  && sel_three |=> active_q == ligs_pkg::LIGS_ALT_TWO)
    else $error("group two dropped");
  no_fast_a: assert property (req != pend_q |=> $stable(active_q))
    else $error("group switched early");
  prim_group_a: assert property (pend_q == ligs_pkg::LIGS_PRIMARY
                  && !sel_two && !sel_three
                  |-> req == ligs_pkg::LIGS_PRIMARY)
    else $error("primary not chosen");

  grp_sw_c: cover property (grp_ev);
  spr_c: cover property (spring_ev);
  third_group_select_c: cover property (active_q == ligs_pkg::LIGS_ALT_TWO);

endmodule // ligs_top

`default_nettype wire

/* ligs_field_model.sv */
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------------
// field side: control switches, scada contacts, breaker state
// ------------------------------------------------------------------
module ligs_field_model (
  input  wire logic       mclk_in,
  input  wire logic [6:0] req_in,
  output logic      [6:0] contact_out
);
  // contacts follow a switch request one clock later, never in the
  // same edge, so the relay never sees a request and its contact at once
  always_ff @(posedge mclk_in) begin
    contact_out <= req_in;
  end
endmodule // ligs_field_model

`default_nettype wire

/* tb_ligs_top.sv */
`timescale 1ns/100ps
`default_nettype none

module tb_ligs_top;
  logic        mclk_in = 1'b0;
  logic        rst_in  = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [6:0]  fld     = 7'h00;
  logic [6:0]  con;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        zone_act;
  logic        permit;
  logic        spring_ev;
  logic [2:0]  grp;
  logic        irq;
  logic [31:0] rd;
  logic        er;
  int          err_total       = 0;
  int          samples_checked = 0;
  int          spr             = 0;

  always #10 mclk_in = ~mclk_in;

  // fld bits: one, two, zone, spring, multi, breaker open, ext open
  ligs_field_model u_ligs_field_model (
    .mclk_in     (mclk_in),
    .req_in      (fld),
    .contact_out (con)
  );

  ligs_top #(.PC_DIV(4)) u_ligs_top (
    .mclk_in                      (mclk_in),
    .rst_in                       (rst_in),
    .prog_input_one_in            (con[0]),
    .prog_input_two_in            (con[1]),
    .zone_coord_enable_in         (con[2]),
    .spring_charge_contact_in     (con[3]),
    .multi_shot_reclose_enable_in (con[4]),
    .breaker_open_in              (con[5]),
    .external_open_in             (con[6]),
    .psel                         (psel),
    .penable                      (penable),
    .pwrite                       (pwrite),
    .paddr                        (paddr),
    .pwdata                       (pwdata),
    .prdata                       (prdata),
    .pready                       (pready),
    .pslverr                      (pslverr),
    .zone_coord_active_out        (zone_act),
    .multi_shot_permit_out        (permit),
    .spring_event_out             (spring_ev),
    .group_onehot_out             (grp),
    .irq_out                      (irq)
  );

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic final_report;
    $display("mismatches %0d checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge mclk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_in);
    penable <= 1'b1;
    // the slave sets the pace; only the watchdog ends a hang
    do begin
      @(posedge mclk_in);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic put(input logic [6:0] v, input int n);
    @(posedge mclk_in);
    fld <= v;
    repeat (n) @(posedge mclk_in);
  endtask

  // a group change takes one to two power cycles plus sync stages
  task automatic wgrp(input logic [2:0] e);
    int n;
    n = 0;
    while (grp !== e && n < 40) begin
      @(posedge mclk_in);
      n++;
    end
    check("group", 32'(e), 32'(grp));
  endtask

  // ------------------------------------------------------------------
  // monitors
  // ------------------------------------------------------------------
  always @(posedge mclk_in) begin
    if (!rst_in && spring_ev === 1'b1) spr++;
    if (!rst_in && grp !== 3'h1 && grp !== 3'h2 &&
        grp !== 3'h4) begin
      err_total++;
      $display("BAD group_onehot expected one hot seen %b", grp);
    end
  end

  initial begin
    // ten thousand clocks; the tests need well under a thousand
    #200_000;
    err_total++;
    $display("BAD watchdog expected finish seen timeout");
    final_report;
  end

  // ------------------------------------------------------------------
  // tests
  // ------------------------------------------------------------------
  initial begin
    repeat (3) @(posedge mclk_in);
    rst_in <= 1'b0;
    apb(1'b0, ligs_pkg::OFF_MAP, 32'h0000_0000);
    check("map_reset", 32'h0000_0000, rd);
    check("group_reset", 32'h0000_0001, 32'(grp));
    check("zone_unmapped", 32'h0000_0001, 32'(zone_act));
    put(7'h54, 4);
    check("permit_unmapped", 32'h0000_0000, 32'(permit));
    apb(1'b1, ligs_pkg::OFF_MAP, 32'h0000_001F);
    put(7'h50, 4);
    check("zone_off", 32'h0000_0000, 32'(zone_act));
    check("permit_on", 32'h0000_0001, 32'(permit));
    put(7'h54, 4);
    check("zone_on", 32'h0000_0001, 32'(zone_act));
    put(7'h14, 4);
    check("permit_no_ext", 32'h0000_0000, 32'(permit));
    apb(1'b1, ligs_pkg::OFF_MASK, 32'h0000_0003);
    put(7'h0C, 4);
    put(7'h04, 4);
    check("spring_closed", 32'h0000_0000, 32'(spr));
    put(7'h24, 4);
    put(7'h2C, 8);
    check("spring_open", 32'h0000_0001, 32'(spr));
    apb(1'b0, ligs_pkg::OFF_SPRCNT, 32'h0000_0000);
    check("spring_count", 32'h0000_0001, rd);
    check("irq_raised", 32'h0000_0001, 32'(irq));
    apb(1'b1, ligs_pkg::OFF_IRQ, 32'h0000_0001);
    apb(1'b0, ligs_pkg::OFF_IRQ, 32'h0000_0000);
    check("irq_cleared", 32'h0000_0000, rd);
    check("irq_low", 32'h0000_0000, 32'(irq));
    apb(1'b1, ligs_pkg::OFF_MAP, 32'h0000_001D);
    put(7'h24, 4);
    put(7'h2C, 4);
    check("spring_unmapped", 32'h0000_0001, 32'(spr));
    put(7'h26, 3);
    check("group_delay", 32'h0000_0001, 32'(grp));
    wgrp(3'h4);
    apb(1'b1, ligs_pkg::OFF_FORCE, 32'h0000_0001);
    repeat (14) @(posedge mclk_in);
    check("group_two_held", 32'h0000_0004, 32'(grp));
    put(7'h24, 1);
    wgrp(3'h2);
    apb(1'b1, ligs_pkg::OFF_FORCE, 32'h0000_0000);
    wgrp(3'h1);
    apb(1'b0, ligs_pkg::OFF_STATUS, 32'h0000_0000);
    check("status_group", 32'h0000_0010, rd & 32'h0000_0070);
    apb(1'b0, ligs_pkg::OFF_IRQ, 32'h0000_0000);
    check("irq_group", 32'h0000_0002, rd & 32'h0000_0002);
    apb(1'b0, 8'h40, 32'h0000_0000);
    check("unmapped_err", 32'h0000_0001, 32'(er));
    final_report;
  end
endmodule // tb_ligs_top

`default_nettype wire
